// ==== rtc_helpers.sv ====
// ==========================================================
// RTC clock pin synchroniser: one pulse per rising edge
module rtc_clk_sync (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic rtc_clk_pin,
   output logic      rtc_tick
);
   logic [2:0] sync_reg;
   logic       level_reg;

   // Three stages; first stage feeds only the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync_reg <= 3'h0;
      end else begin
         sync_reg <= {sync_reg[1:0], rtc_clk_pin};
      end
   end

   // Level moves only when stages two and three agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         level_reg <= 1'b0;
         rtc_tick  <= 1'b0;
      end else begin
         rtc_tick <= 1'b0;
         if (sync_reg[1] == sync_reg[2]) begin
            level_reg <= sync_reg[2];
            rtc_tick  <= sync_reg[2] && !level_reg;
         end
      end
   end
endmodule

// ==========================================================
// Access window: open for a fixed number of RTC clocks
module access_window_timer #(
   parameter int TICKS = 1024
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic start,
   input  wire logic rtc_tick,
   output logic      open_flag
);
   localparam int CW = $clog2(TICKS + 1);
   localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

   logic [CW-1:0] count_reg;

   // A fresh password restarts the full window
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         open_flag <= 1'b0;
         count_reg <= '0;
      end else if (start) begin
         open_flag <= 1'b1;
         count_reg <= '0;
      end else if (open_flag && rtc_tick) begin
         count_reg <= count_reg + 1'b1;
         if (count_reg == LAST) begin
            open_flag <= 1'b0;
         end
      end
   end
endmodule

// ==== rtc_pkg.sv ====
package rtc_pkg;

   // ==========================================================
   // Address map
   localparam logic [31:0] RTC_BASE_ADDR      = 32'h4000_8000;
   localparam int          NUM_REGS           = 13;
   localparam logic [7:0]  OFS_INIT_KEY       = 8'h00;
   localparam logic [7:0]  OFS_ACCESS_UNLOCK  = 8'h04;
   localparam logic [7:0]  OFS_FREQ_TRIM      = 8'h08;
   localparam logic [7:0]  OFS_TIME_COUNT     = 8'h0C;
   localparam logic [7:0]  OFS_CALENDAR_COUNT = 8'h10;
   localparam logic [7:0]  OFS_HOUR_FORMAT    = 8'h14;
   localparam logic [7:0]  OFS_WEEKDAY        = 8'h18;
   localparam logic [7:0]  OFS_ALARM_TIME     = 8'h1C;
   localparam logic [7:0]  OFS_ALARM_CALENDAR = 8'h20;
   localparam logic [7:0]  OFS_LEAP_YEAR      = 8'h24;
   localparam logic [7:0]  OFS_IRQ_ENABLE     = 8'h28;
   localparam logic [7:0]  OFS_IRQ_FLAGS      = 8'h2C;
   localparam logic [7:0]  OFS_TICK_PERIOD    = 8'h30;

   // Word indices, used for storage and decode
   localparam logic [3:0]  IDX_INIT_KEY       = 4'h0;
   localparam logic [3:0]  IDX_ACCESS_UNLOCK  = 4'h1;
   localparam logic [3:0]  IDX_FREQ_TRIM      = 4'h2;
   localparam logic [3:0]  IDX_TIME_COUNT     = 4'h3;
   localparam logic [3:0]  IDX_CALENDAR_COUNT = 4'h4;
   localparam logic [3:0]  IDX_HOUR_FORMAT    = 4'h5;
   localparam logic [3:0]  IDX_WEEKDAY        = 4'h6;
   localparam logic [3:0]  IDX_ALARM_TIME     = 4'h7;
   localparam logic [3:0]  IDX_ALARM_CALENDAR = 4'h8;
   localparam logic [3:0]  IDX_LEAP_YEAR      = 4'h9;
   localparam logic [3:0]  IDX_IRQ_ENABLE     = 4'hA;
   localparam logic [3:0]  IDX_IRQ_FLAGS      = 4'hB;
   localparam logic [3:0]  IDX_TICK_PERIOD    = 4'hC;

   // ==========================================================
   // Reset values and implemented bits
   localparam logic [31:0] RST_FREQ_TRIM      = 32'h0000_0700;
   localparam logic [31:0] RST_CALENDAR       = 32'h0005_0101;
   localparam logic [31:0] RST_HOUR_FORMAT    = 32'h0000_0001;
   localparam logic [31:0] RST_WEEKDAY        = 32'h0000_0006;
   localparam logic [31:0] RST_ZERO           = 32'h0000_0000;
   localparam logic [31:0] MASK_FREQ_TRIM     = 32'h0000_0F3F;
   localparam logic [31:0] MASK_TIME          = 32'h003F_7F7F;
   localparam logic [31:0] MASK_CALENDAR      = 32'h00FF_1F3F;
   localparam logic [31:0] MASK_HOUR_FORMAT   = 32'h0000_0001;
   localparam logic [31:0] MASK_WEEKDAY       = 32'h0000_0007;
   localparam logic [31:0] MASK_IRQ           = 32'h0000_0003;
   localparam logic [31:0] MASK_TICK_PERIOD   = 32'h0000_000F;

   // ==========================================================
   // Keys, status bits and timing
   localparam logic [31:0] INIT_KEY_VALUE     = 32'hA5EB_1357;
   localparam logic [15:0] UNLOCK_PASSWORD    = 16'hA965;
   localparam int          ACTIVE_STATUS_BIT  = 0;
   localparam int          OPEN_FLAG_BIT      = 16;
   localparam int          WINDOW_RTC_CLOCKS  = 1024;
   localparam logic [1:0]  WRITE_DELAY_TICKS  = 2'h2;

endpackage

// ==== rtc_regs.sv ====
// How it works
// - Held in reset until init key written
// - Init key upper bits write-only, read zero
// - Init key bit 0 shows active status
// - Password 0xA965 opens access for 1024 clocks
// - Open flag sets, clears after 1024 clocks
// - Open: all registers read/write except leap-year
// - Shut: control registers RW, time registers read-only
// - Shut: trim, alarms, tick period fully hidden
// - Leap-year register always read-only
// - Thirteen word registers, offsets 0x00 to 0x30
// - Documented reset values, others zero
// - Writes land after two RTC clocks
//
// The AHB-Lite interface to the registers is this design's own decision.
module rtc_regs
   import rtc_pkg::*;
#(
   parameter int WINDOW_TICKS = WINDOW_RTC_CLOCKS
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        rtc_clk_pin,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   output logic             active_status,
   output logic             access_open_flag
);

   // ==========================================================
   // Types and decode helpers
   // Bus handshake states; WCAP is the data phase that takes hwdata
   typedef enum logic [1:0] {
      BUS_IDLE  = 2'b00,
      BUS_READ  = 2'b01,
      BUS_WRITE = 2'b10,
      BUS_WCAP  = 2'b11
   } bus_state_t;

   // Reset value of each stored word
   function automatic logic [31:0] reg_reset(input logic [3:0] idx);
      case (idx)
         IDX_FREQ_TRIM:      reg_reset = RST_FREQ_TRIM;
         IDX_CALENDAR_COUNT: reg_reset = RST_CALENDAR;
         IDX_HOUR_FORMAT:    reg_reset = RST_HOUR_FORMAT;
         IDX_WEEKDAY:        reg_reset = RST_WEEKDAY;
         default:            reg_reset = RST_ZERO;
      endcase
   endfunction

   // Bits that hold state; the rest read as zero
   function automatic logic [31:0] reg_mask(input logic [3:0] idx);
      case (idx)
         IDX_FREQ_TRIM:                         reg_mask = MASK_FREQ_TRIM;
         IDX_TIME_COUNT, IDX_ALARM_TIME:        reg_mask = MASK_TIME;
         IDX_CALENDAR_COUNT, IDX_ALARM_CALENDAR: reg_mask = MASK_CALENDAR;
         IDX_HOUR_FORMAT:                       reg_mask = MASK_HOUR_FORMAT;
         IDX_WEEKDAY:                           reg_mask = MASK_WEEKDAY;
         IDX_IRQ_ENABLE, IDX_IRQ_FLAGS:         reg_mask = MASK_IRQ;
         IDX_TICK_PERIOD:                       reg_mask = MASK_TICK_PERIOD;
         default:                               reg_mask = RST_ZERO;
      endcase
   endfunction

   // Locked registers are hidden entirely while the window is shut
   function automatic logic reg_readable(input logic [3:0] idx, input logic open);
      case (idx)
         IDX_FREQ_TRIM, IDX_ALARM_TIME, IDX_ALARM_CALENDAR, IDX_TICK_PERIOD:
            reg_readable = open;
         default:
            reg_readable = (idx < 4'(NUM_REGS));
      endcase
   endfunction

   // Control words stay writable while shut; leap-year never is
   function automatic logic reg_writable(input logic [3:0] idx, input logic open);
      case (idx)
         IDX_INIT_KEY, IDX_ACCESS_UNLOCK, IDX_HOUR_FORMAT, IDX_IRQ_ENABLE, IDX_IRQ_FLAGS:
            reg_writable = 1'b1;
         IDX_LEAP_YEAR:
            reg_writable = 1'b0;
         default:
            reg_writable = open && (idx < 4'(NUM_REGS));
      endcase
   endfunction

   // ==========================================================
   // Declarations
   bus_state_t    bus_state_reg;
   logic [3:0]    idx_reg;
   logic          hit_reg;
   // Crossing buffer: one write waiting for two RTC edges
   logic          pending_valid_reg;
   logic [3:0]    pending_idx_reg;
   logic [31:0]   pending_data_reg;
   logic [1:0]    pending_ticks_reg;
   logic          active_reg;
   logic [31:0]   regs_reg [NUM_REGS];
   logic          rtc_tick;
   logic          open_flag;
   logic          accept;
   logic          addr_hit;
   logic [3:0]    addr_idx;
   logic          commit;
   logic          unlock_start;
   logic [31:0]   read_word;

   // ==========================================================
   // RTC clock edge detection and the access window
   // The pin is sampled by clk; only its rising edges matter
   rtc_clk_sync u_sync (
      .clk         (clk),
      .nrst        (nrst),
      .rtc_clk_pin (rtc_clk_pin),
      .rtc_tick    (rtc_tick)
   );

   access_window_timer #(
      .TICKS (WINDOW_TICKS)
   ) u_window (
      .clk       (clk),
      .nrst      (nrst),
      .start     (unlock_start),
      .rtc_tick  (rtc_tick),
      .open_flag (open_flag)
   );

   // ==========================================================
   // Address decode
   // Only the low byte is decoded; the fabric selects the block base
   // Misaligned or out-of-range offsets miss and behave as unmapped
   assign accept   = hsel && htrans[1] && hready;
   assign addr_idx = haddr[5:2];
   assign addr_hit = (haddr[7:6] == 2'h0) && (haddr[1:0] == 2'h0)
                     && (addr_idx < 4'(NUM_REGS));

   // ==========================================================
   // Bus state machine
   // Every transfer takes one wait state; writes wait further while an
   // earlier write is still crossing into the RTC clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_state_reg <= BUS_IDLE;
         hreadyout     <= 1'b1;
         idx_reg       <= 4'h0;
         hit_reg       <= 1'b0;
      end else begin
         unique case (bus_state_reg)
            BUS_IDLE, BUS_WCAP: begin
               if (accept) begin
                  idx_reg       <= addr_idx;
                  hit_reg       <= addr_hit;
                  hreadyout     <= 1'b0;
                  bus_state_reg <= hwrite ? BUS_WRITE : BUS_READ;
               end else begin
                  bus_state_reg <= BUS_IDLE;
               end
            end
            BUS_READ: begin
               // Registered read data costs exactly one wait state
               hreadyout     <= 1'b1;
               bus_state_reg <= BUS_IDLE;
            end
            BUS_WRITE: begin
               // Hold off until the crossing buffer is free
               if (!pending_valid_reg) begin
                  hreadyout     <= 1'b1;
                  bus_state_reg <= BUS_WCAP;
               end
            end
         endcase
      end
   end

   // Response is always OKAY
   // Kept in a flop so that every bus output leaves a register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // ==========================================================
   // Read data
   // Status bits come from flags already clocked by clk
   always_comb begin
      read_word = 32'h0000_0000;
      if (hit_reg && reg_readable(idx_reg, open_flag)) begin
         unique case (idx_reg)
            IDX_INIT_KEY: begin
               // Key bits 31:1 are write-only and always read back as zero
               read_word[ACTIVE_STATUS_BIT] = active_reg;
            end
            IDX_ACCESS_UNLOCK: begin
               read_word[OPEN_FLAG_BIT] = open_flag;
            end
            default: begin
               read_word = regs_reg[idx_reg] & reg_mask(idx_reg);
            end
         endcase
      end
   end

   // Hidden or unmapped words read as zero
   // Loaded only at the end of a read, so hrdata stands until the next
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hrdata <= 32'h0000_0000;
      end else if (bus_state_reg == BUS_READ) begin
         hrdata <= read_word;
      end
   end

   // ==========================================================
   // Write crossing
   // Permission is checked against the window at the moment software
   // writes; a write that later lands after the window shut still lands
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pending_valid_reg <= 1'b0;
         pending_idx_reg   <= 4'h0;
         pending_data_reg  <= 32'h0000_0000;
         pending_ticks_reg <= 2'h0;
      end else if (bus_state_reg == BUS_WCAP) begin
         // One write in flight at most; the bus stalls any later one
         // Until the key is accepted only the init key may be written
         if (hit_reg && reg_writable(idx_reg, open_flag)
             && (active_reg || idx_reg == IDX_INIT_KEY)) begin
            pending_valid_reg <= 1'b1;
            pending_idx_reg   <= idx_reg;
            pending_data_reg  <= hwdata;
            pending_ticks_reg <= 2'h0;
         end
      end else if (pending_valid_reg && rtc_tick) begin
         pending_ticks_reg <= pending_ticks_reg + 2'h1;
         if (commit) begin
            pending_valid_reg <= 1'b0;
         end
      end
   end

   // Commit on the second RTC clock edge after capture
   // Counting synced edges keeps the delay in RTC periods at any clk rate that samples each pin level at least twice
   assign commit = pending_valid_reg && rtc_tick
                   && (pending_ticks_reg == WRITE_DELAY_TICKS - 2'h1);

   assign unlock_start = commit && (pending_idx_reg == IDX_ACCESS_UNLOCK)
                         && (pending_data_reg[15:0] == UNLOCK_PASSWORD);

   // ==========================================================
   // Initialisation
   // Once set nothing but the bus reset clears it
   // A wrong key changes nothing, so software may simply try again
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         active_reg <= 1'b0;
      end else if (commit && pending_idx_reg == IDX_INIT_KEY
                   && pending_data_reg == INIT_KEY_VALUE) begin
         active_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Register storage
   // Init key, unlock and leap-year words hold no stored bits
   // Reserved bits are dropped on entry and never come back on a read
   generate
      for (genvar i = 0; i < NUM_REGS; i++) begin : g_store
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               regs_reg[i] <= reg_reset(4'(i));
            end else if (commit && pending_idx_reg == 4'(i)) begin
               regs_reg[i] <= pending_data_reg & reg_mask(4'(i));
            end
         end
      end
   endgenerate

   // ==========================================================
   // Status outputs
   // Registered copies, so the pins never show decode glitches
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         active_status    <= 1'b0;
         access_open_flag <= 1'b0;
      end else begin
         active_status    <= active_reg;
         access_open_flag <= open_flag;
      end
   end

endmodule

// ==== rtc_regs_chk.sv ====
// ==========================================================
// Bus and window checks on the register front end
module rtc_regs_chk #(
   parameter int WINDOW_TICKS = 1024
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        rtc_clk_pin,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic        active_status,
   input wire logic        access_open_flag
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0]  rd_ofs;
   logic        rd_pend;
   logic        rdy_q;
   logic        rtc_q;
   logic [15:0] open_edges;
   wire         take    = hsel && htrans[1] && hready && hreadyout;
   wire         rd_done = rd_pend && hreadyout && !rdy_q;
   wire         hidden  = rd_ofs == 8'h08 || rd_ofs == 8'h1C || rd_ofs == 8'h20 ||
                          rd_ofs == 8'h30 || rd_ofs > 8'h30;

   // Remember the offset of the read in flight
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_pend <= 1'b0;
         rd_ofs  <= 8'h00;
         rdy_q   <= 1'b1;
      end else begin
         rdy_q <= hreadyout;
         if (take) begin
            rd_pend <= !hwrite;
            rd_ofs  <= haddr[7:0];
         end else if (rd_done) begin
            rd_pend <= 1'b0;
         end
      end
   end

   // Raw pin edges while open; leads the design's sync by a few clocks, hence the slack
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rtc_q      <= 1'b0;
         open_edges <= 16'h0000;
      end else begin
         rtc_q <= rtc_clk_pin;
         if (!access_open_flag) open_edges <= 16'h0000;
         else if (rtc_clk_pin && !rtc_q) open_edges <= open_edges + 16'h0001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // ==========================================================
   // Assertions
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("error response seen");
   property p_read_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
   property p_write_wait; take && hwrite |=> !hreadyout; endproperty
   a_write_wait: assert property (p_write_wait) else $error("write not stalled");
   property p_active_sticky; active_status |=> active_status; endproperty
   a_active_sticky: assert property (p_active_sticky) else $error("active dropped");
   property p_open_after_active; $rose(access_open_flag) |-> active_status; endproperty
   a_open_after_active: assert property (p_open_after_active) else $error("open early");
   property p_window_min; $fell(access_open_flag) |-> open_edges >= WINDOW_TICKS - 1; endproperty
   a_window_min: assert property (p_window_min) else $error("window too short");
   property p_window_max; access_open_flag |-> open_edges <= WINDOW_TICKS + 1; endproperty
   a_window_max: assert property (p_window_max) else $error("window too long");
   property p_key_read; rd_done && rd_ofs == 8'h00 |-> hrdata[31:1] == 31'h0; endproperty
   a_key_read: assert property (p_key_read) else $error("key bits not zero");
   property p_hidden_read;
      rd_done && hidden && !access_open_flag && !$past(access_open_flag) |-> hrdata == 32'h0;
   endproperty
   a_hidden_read: assert property (p_hidden_read) else $error("hidden data seen");
   property p_leap_read; rd_done && rd_ofs == 8'h24 |-> hrdata == 32'h0; endproperty
   a_leap_read: assert property (p_leap_read) else $error("leap year not zero");
   property p_unlock_read;
      rd_done && rd_ofs == 8'h04 |-> hrdata[31:17] == 15'h0 && hrdata[15:0] == 16'h0;
   endproperty
   a_unlock_read: assert property (p_unlock_read) else $error("unlock bits seen");
endmodule

bind rtc_regs rtc_regs_chk #(.WINDOW_TICKS(WINDOW_TICKS)) u_chk (
   .clk(clk), .nrst(nrst), .rtc_clk_pin(rtc_clk_pin), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .active_status(active_status),
   .access_open_flag(access_open_flag)
);

// ==== testbench.sv ====
module testbench
   import rtc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk, nrst, rtc_clk_pin, hsel, hwrite;
   logic [31:0] haddr, hwdata, ev [13];
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire         hready, hreadyout, hresp, active_status, access_open_flag;
   wire  [31:0] hrdata;
   int          fail_count = 0;
   int          checks_done = 0;
   logic [7:0]  wo [8] = '{8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h30};
   logic [31:0] wd [8] = '{32'hA0B, 32'h123456, 32'h201231, 32'h3, 32'h10203, 32'h110522,
                           32'h1, 32'h5};

   // ==========================================================
   // Clocks; the RTC pin runs fast so windows stay short in simulation
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      rtc_clk_pin = 1'b0;
      #3;
      forever #80 rtc_clk_pin = ~rtc_clk_pin;
   end
   assign hready = hreadyout;

   rtc_regs #(.WINDOW_TICKS(64)) uut (
      .clk(clk), .nrst(nrst), .rtc_clk_pin(rtc_clk_pin), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .active_status(active_status),
      .access_open_flag(access_open_flag)
   );

   // ==========================================================
   // Bus tasks and comparisons
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t ns: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk_word({31'h0, g}, {31'h0, e});
   endtask
   // Address phase held until ready, then data phase held until ready again
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= RTC_BASE_ADDR + {24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk_word(r, e);
      chk_bit(hresp, 1'b0);
   endtask
   // Enough slow clocks for the last write to land, plus sync slack
   task automatic settle();
      repeat (3) @(posedge rtc_clk_pin);
      repeat (8) @(posedge clk);
   endtask
   task automatic wait_flag(input logic v);
      int n;
      n = 0;
      while (access_open_flag !== v && n < 20000) begin
         @(posedge clk);
         n++;
      end
      chk_bit(access_open_flag, v);
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================================
   // Watchdog against a hung handshake
   initial begin
      #400_000;
      fail_count++;
      $display("wrong value at %0t ns: run timed out", $time);
      end_of_test();
   end

   // ==========================================================
   // Test sequence
   initial begin
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      nrst = 1'b0;
      ev = '{32'h0, 32'h0, 32'h0, 32'h0, RST_CALENDAR, 32'h1, 32'h6, 32'h0, 32'h0, 32'h0,
             32'h0, 32'h0, 32'h0};
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk_bit(active_status, 1'b0);
      for (int i = 0; i < 13; i++) rd(8'(i * 4), ev[i]);
      rd(8'h34, 32'h0);
      wr(OFS_IRQ_ENABLE, 32'h3);
      wr(OFS_ACCESS_UNLOCK, 32'hA965);
      wr(OFS_INIT_KEY, 32'hA5EB_1356);
      settle();
      rd(OFS_IRQ_ENABLE, 32'h0);
      chk_bit(active_status, 1'b0);
      chk_bit(access_open_flag, 1'b0);
      wr(OFS_INIT_KEY, INIT_KEY_VALUE);
      chk_bit(active_status, 1'b0);
      settle();
      rd(OFS_INIT_KEY, 32'h1);
      wr(OFS_INIT_KEY, 32'h0);
      wr(OFS_IRQ_ENABLE, 32'h3);
      rd(OFS_IRQ_ENABLE, 32'h0);
      wr(OFS_HOUR_FORMAT, 32'h0);
      wr(OFS_IRQ_FLAGS, 32'h2);
      wr(OFS_TIME_COUNT, 32'h123456);
      wr(OFS_CALENDAR_COUNT, 32'h201231);
      wr(OFS_WEEKDAY, 32'h3);
      wr(OFS_FREQ_TRIM, 32'hA0B);
      wr(8'h34, 32'hF);
      settle();
      chk_bit(active_status, 1'b1);
      rd(OFS_IRQ_ENABLE, 32'h3);
      rd(OFS_HOUR_FORMAT, 32'h0);
      rd(OFS_IRQ_FLAGS, 32'h2);
      rd(OFS_TIME_COUNT, 32'h0);
      rd(OFS_CALENDAR_COUNT, RST_CALENDAR);
      rd(OFS_WEEKDAY, RST_WEEKDAY);
      rd(8'h34, 32'h0);
      wr(OFS_ACCESS_UNLOCK, 32'hA964);
      settle();
      chk_bit(access_open_flag, 1'b0);
      wr(OFS_ACCESS_UNLOCK, 32'hA965);
      wait_flag(1'b1);
      rd(OFS_ACCESS_UNLOCK, 32'h0001_0000);
      rd(OFS_FREQ_TRIM, RST_FREQ_TRIM);
      for (int i = 0; i < 8; i++) wr(wo[i], wd[i]);
      settle();
      for (int i = 0; i < 8; i++) rd(wo[i], (wo[i] == 8'h24) ? 32'h0 : wd[i]);
      wait_flag(1'b0);
      rd(OFS_FREQ_TRIM, 32'h0);
      rd(OFS_ALARM_TIME, 32'h0);
      rd(OFS_TIME_COUNT, 32'h123456);
      end_of_test();
   end
endmodule
